// *** rtl/tti_defs.svh ***
`ifndef TTI_DEFS_SVH
`define TTI_DEFS_SVH

// Trigger source select codes
`define TTI_TRG_MOD     2'h0
`define TTI_TRG_RTC     2'h1
`define TTI_TRG_MATCH   2'h2
`define TTI_TRG_INIT    2'h3
`define TTI_DLY_W       8
`define TTI_NFAULT      4
`endif

// *** rtl/tti_pkg.sv ***
package tti_pkg;
    typedef enum logic [1:0] {
        TTI_SRC_MOD   = 2'h0,
        TTI_SRC_RTC   = 2'h1,
        TTI_SRC_MATCH = 2'h2,
        TTI_SRC_INIT  = 2'h3
    } tti_src_t;
    typedef enum logic [1:0] {
        TTI_DLY_IDLE = 2'b01,
        TTI_DLY_RUN  = 2'b10
    } tti_dly_state_t;
endpackage : tti_pkg

// *** rtl/tti_dly_if.sv ***
`timescale 1ns/1ps
interface tti_dly_if;
    logic       start;
    logic [7:0] count;
    logic       fire;
    modport ctl (output start, output count, input fire);
    modport dly (input start, input count, output fire);
endinterface : tti_dly_if

// *** rtl/tti_delay.sv ***
`timescale 1ns/1ps
`include "tti_defs.svh"
module tti_delay (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Delay request
    tti_dly_if.dly   dl
);
    tti_pkg::tti_dly_state_t state_q;
    logic [`TTI_DLY_W-1:0]   cnt_q;
    logic                    fire_q;

    // Restart on a new trigger; a trigger during a run restarts the delay
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= tti_pkg::TTI_DLY_IDLE;
            cnt_q   <= 8'h00;
            fire_q  <= 1'b0;
        end
        else
        begin
            fire_q <= 1'b0;
            unique case (state_q)
                tti_pkg::TTI_DLY_IDLE:
                begin
                    if (dl.start)
                    begin
                        if (dl.count == 8'h00)
                            fire_q <= 1'b1;
                        else
                        begin
                            cnt_q   <= dl.count;
                            state_q <= tti_pkg::TTI_DLY_RUN;
                        end
                    end
                end
                tti_pkg::TTI_DLY_RUN:
                begin
                    if (dl.start)
                        cnt_q <= dl.count;
                    else if (cnt_q == 8'h01)
                    begin
                        fire_q  <= 1'b1;
                        state_q <= tti_pkg::TTI_DLY_IDLE;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                default: state_q <= tti_pkg::TTI_DLY_IDLE;
            endcase
        end
    end
    assign dl.fire = fire_q;

    chk_zero_delay: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        state_q == tti_pkg::TTI_DLY_IDLE && dl.start && dl.count == 8'h00
        |=> dl.fire)
        else $error("zero delay did not fire next cycle");
endmodule : tti_delay

// *** rtl/tti_top.sv ***
`timescale 1ns/1ps
`include "tti_defs.svh"
module tti_top (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // System option register two fields
    input  wire logic       opt_cmp_capture,
    input  wire logic       opt_cmp_rx,
    input  wire logic       opt_tx_mod,
    input  wire logic       opt_rtc_pin_en,
    input  wire logic [1:0] opt_trg_sel,
    input  wire logic [7:0] opt_trg_delay,
    input  wire logic       sw_pwm_sync_bit,
    // On-chip sources
    input  wire logic       analog_comparator_out,
    input  wire logic       timer_a_ch0_out,
    input  wire logic       six_init_trig,
    input  wire logic [5:0] six_match_trig,
    input  wire logic       modulo_timer_ovf,
    input  wire logic       rtc_ovf,
    input  wire logic       serial_zero_tx,
    // Pins
    input  wire logic       fault_pin_one,
    input  wire logic       fault_pin_two,
    input  wire logic       timer_b_ch0_pin,
    input  wire logic       serial_zero_rx_pin,
    // Routed outputs
    output logic [2:0]      six_sync,
    output logic [3:0]      six_fault,
    output logic            timer_b_ch0_capture,
    output logic            timer_a_ch1_capture,
    output logic            serial_zero_rx,
    output logic            serial_zero_tx_pin,
    output logic            converter_hw_trig,
    output logic            rtc_toggle_pin
);
    logic       rst_s1_q;
    logic       rst_n_q;
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [2:0] sync_q;
    logic [3:0] fault_q;
    logic       capb_q;
    logic       capa_q;
    logic       rx_q;
    logic       tx_q;
    logic       trig_q;
    logic       rtc_pin_q;
    logic       sw_sync_q;
    logic       match_any;
    tti_dly_if  dlyi ();

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Two-flop synchronisers for the pins routed inward
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            // Receive pin idles high; a low reset would fake a start bit
            pin_s1_q <= 4'h8;
            pin_s2_q <= 4'h8;
        end
        else
        begin
            pin_s1_q <= {serial_zero_rx_pin, timer_b_ch0_pin,
                         fault_pin_two, fault_pin_one};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Sync bit is a write strobe; edge-detect it so one write gives one pulse
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sw_sync_q <= 1'b0;
            sync_q    <= 3'h0;
        end
        else
        begin
            sw_sync_q <= sw_pwm_sync_bit;
            sync_q[0] <= analog_comparator_out;
            sync_q[1] <= timer_a_ch0_out;
            sync_q[2] <= sw_pwm_sync_bit & ~sw_sync_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
            fault_q <= 4'h0;
        else
        begin
            fault_q[0] <= analog_comparator_out;
            fault_q[2:1] <= pin_s2_q[1:0];
            fault_q[3] <= 1'b0;
        end
    end

    // Pin paths lag the comparator paths by the two synchroniser flops
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            capb_q <= 1'b0;
            capa_q <= 1'b1;
            rx_q   <= 1'b1;
            tx_q   <= 1'b1;
        end
        else
        begin
            capb_q <= opt_cmp_capture ? analog_comparator_out
                                      : pin_s2_q[2];
            rx_q   <= opt_cmp_rx ? analog_comparator_out
                                 : pin_s2_q[3];
            capa_q <= opt_cmp_rx ? analog_comparator_out
                                 : pin_s2_q[3];
            tx_q   <= opt_tx_mod ? (serial_zero_tx & timer_a_ch0_out)
                                 : serial_zero_tx;
        end
    end

    // Only init and any match feed the delay; modulo and RTC overflows bypass it
    assign match_any   = |six_match_trig;
    assign dlyi.count  = opt_trg_delay;
    assign dlyi.start  = (opt_trg_sel == `TTI_TRG_INIT) ? six_init_trig
                       : (opt_trg_sel == `TTI_TRG_MATCH) ? match_any
                       : 1'b0;

    tti_delay u_delay (
        .clk_sys (clk_sys),
        .rst_n   (rst_n_q),
        .dl      (dlyi.dly)
    );

    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
            trig_q <= 1'b0;
        else
            unique case (opt_trg_sel)
                `TTI_TRG_MOD:   trig_q <= modulo_timer_ovf;
                `TTI_TRG_RTC:   trig_q <= rtc_ovf;
                `TTI_TRG_MATCH,
                `TTI_TRG_INIT:  trig_q <= dlyi.fire;
            endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
            rtc_pin_q <= 1'b0;
        else if (opt_rtc_pin_en && rtc_ovf)
            rtc_pin_q <= ~rtc_pin_q;
    end

    assign six_sync            = sync_q;
    assign six_fault           = fault_q;
    assign timer_b_ch0_capture = capb_q;
    assign timer_a_ch1_capture = capa_q;
    assign serial_zero_rx      = rx_q;
    assign serial_zero_tx_pin  = tx_q;
    assign converter_hw_trig   = trig_q;
    assign rtc_toggle_pin      = rtc_pin_q;

    sequence s_sw_write;
        !sw_pwm_sync_bit ##1 sw_pwm_sync_bit;
    endsequence
    sequence s_one_pulse;
        six_sync[2] ##1 !six_sync[2];
    endsequence
    chk_sw_sync_pulse: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        s_sw_write |=> s_one_pulse)
        else $error("software sync pulse wrong");
    chk_cmp_sync: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        1'b1 |=> six_sync[0] == $past(analog_comparator_out))
        else $error("sync 0 not comparator");
    chk_a_sync: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        1'b1 |=> six_sync[1] == $past(timer_a_ch0_out))
        else $error("sync 1 not timer a");
    chk_fault_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        1'b1 |=> six_fault[0] == $past(analog_comparator_out))
        else $error("fault 0 not comparator");
    chk_fault_pins: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        1'b1 |-> ##3 six_fault[1] == $past(fault_pin_one, 3))
        else $error("fault 1 pin path wrong");
    chk_fault_unused: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        !six_fault[3])
        else $error("fault 3 asserted");
    chk_cap_route: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        opt_cmp_capture
        |=> timer_b_ch0_capture == $past(analog_comparator_out))
        else $error("capture route wrong");
    chk_rx_ignore: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        opt_cmp_rx |=> serial_zero_rx == $past(analog_comparator_out))
        else $error("receive pin not ignored");
    chk_tx_mod: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        opt_tx_mod && !timer_a_ch0_out |=> !serial_zero_tx_pin)
        else $error("transmit not modulated");
    chk_rtc_toggle: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        opt_rtc_pin_en && rtc_ovf |=> rtc_toggle_pin != $past(rtc_toggle_pin))
        else $error("rtc pin did not toggle");
    chk_mod_trig: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        opt_trg_sel == `TTI_TRG_MOD && modulo_timer_ovf |=> converter_hw_trig)
        else $error("modulo trigger lost");
    chk_rtc_trig: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        opt_trg_sel == `TTI_TRG_RTC && rtc_ovf |=> converter_hw_trig)
        else $error("rtc trigger lost");
    chk_delay_trig: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        (opt_trg_sel == `TTI_TRG_MATCH || opt_trg_sel == `TTI_TRG_INIT)
        && dlyi.fire |=> converter_hw_trig)
        else $error("delayed trigger lost");
    chk_rx_capture: assert property (
        @(posedge clk_sys) disable iff (!rst_n_q)
        timer_a_ch1_capture == serial_zero_rx)
        else $error("channel 1 capture not on receive");
endmodule : tti_top

// *** test/tti_src_model.sv ***
`timescale 1ns/1ps
module tti_src_model (
    // Request from the bench
    input  wire logic [1:0] kind,
    input  wire logic       go,
    input  wire logic [2:0] lane,
    // Trigger pulses
    output logic            mod_ovf,
    output logic            rtc_ovf,
    output logic            init_trig,
    output logic [5:0]      match_trig
);
    // Combinational, so a pulse lasts exactly as long as go is held
    assign mod_ovf    = go && kind == 2'h0;
    assign rtc_ovf    = go && kind == 2'h1;
    assign init_trig  = go && kind == 2'h3;
    assign match_trig = {6{go && kind == 2'h2}} & (6'h01 << lane);
endmodule : tti_src_model

// *** test/timer_trigger_interconnect_test.sv ***
`timescale 1ns/1ps
module timer_trigger_interconnect_test;
    logic        clk_sys, arst_n;
    logic        opt_cmp_capture, opt_cmp_rx, opt_tx_mod, opt_rtc_pin_en;
    logic [1:0]  opt_trg_sel;
    logic [7:0]  opt_trg_delay;
    logic        sw_pwm_sync_bit, analog_comparator_out, timer_a_ch0_out;
    logic        six_init_trig, modulo_timer_ovf, rtc_ovf, serial_zero_tx;
    logic [5:0]  six_match_trig;
    logic        fault_pin_one, fault_pin_two;
    logic        timer_b_ch0_pin, serial_zero_rx_pin;
    logic [2:0]  six_sync;
    logic [3:0]  six_fault;
    logic        timer_b_ch0_capture, timer_a_ch1_capture, serial_zero_rx;
    logic        serial_zero_tx_pin, converter_hw_trig, rtc_toggle_pin;
    logic [1:0]  kind;
    logic        go;
    logic [2:0]  lane;
    logic [12:0] obs;
    int          n_mismatch = 0;
    int          n_checks = 0;

    assign obs = {six_sync, six_fault, timer_b_ch0_capture,
                  timer_a_ch1_capture, serial_zero_rx, serial_zero_tx_pin,
                  converter_hw_trig, rtc_toggle_pin};

    tti_top uut (
        .clk_sys               (clk_sys),
        .arst_n                (arst_n),
        .opt_cmp_capture       (opt_cmp_capture),
        .opt_cmp_rx            (opt_cmp_rx),
        .opt_tx_mod            (opt_tx_mod),
        .opt_rtc_pin_en        (opt_rtc_pin_en),
        .opt_trg_sel           (opt_trg_sel),
        .opt_trg_delay         (opt_trg_delay),
        .sw_pwm_sync_bit       (sw_pwm_sync_bit),
        .analog_comparator_out (analog_comparator_out),
        .timer_a_ch0_out       (timer_a_ch0_out),
        .six_init_trig         (six_init_trig),
        .six_match_trig        (six_match_trig),
        .modulo_timer_ovf      (modulo_timer_ovf),
        .rtc_ovf               (rtc_ovf),
        .serial_zero_tx        (serial_zero_tx),
        .fault_pin_one         (fault_pin_one),
        .fault_pin_two         (fault_pin_two),
        .timer_b_ch0_pin       (timer_b_ch0_pin),
        .serial_zero_rx_pin    (serial_zero_rx_pin),
        .six_sync              (six_sync),
        .six_fault             (six_fault),
        .timer_b_ch0_capture   (timer_b_ch0_capture),
        .timer_a_ch1_capture   (timer_a_ch1_capture),
        .serial_zero_rx        (serial_zero_rx),
        .serial_zero_tx_pin    (serial_zero_tx_pin),
        .converter_hw_trig     (converter_hw_trig),
        .rtc_toggle_pin        (rtc_toggle_pin)
    );
    tti_src_model model (.kind(kind), .go(go), .lane(lane),
        .mod_ovf(modulo_timer_ovf), .rtc_ovf(rtc_ovf),
        .init_trig(six_init_trig), .match_trig(six_match_trig));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    task automatic chk_vec(input logic [12:0] got, input logic [12:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_vec

    task automatic chk_n(input int got, input int exp);
        n_checks++;
        if (got != exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t cycles=%h exp=%h", $time, got, exp);
        end
    endtask : chk_n

    task automatic cyc();
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : cyc

    // Counts edges until obs[b] reaches v; go is dropped after one cycle
    task automatic lat(input int b, input logic v, input int e);
        int k;
        k = 0;
        while (k < 300 && obs[b] !== v)
        begin
            cyc();
            if (k == 0)
                go = 1'b0;
            k++;
        end
        chk_n(k, e);
    endtask : lat

    task automatic t_sync();
        analog_comparator_out = 1'b1;
        lat(10, 1'b1, 1);
        chk_vec(obs[12:6], 7'h11);
        analog_comparator_out = 1'b0;
        timer_a_ch0_out = 1'b1;
        lat(11, 1'b1, 1);
        sw_pwm_sync_bit = 1'b1;
        lat(12, 1'b1, 1);
        cyc();
        chk_vec(obs[12], 1'b0);
        sw_pwm_sync_bit = 1'b0;
        timer_a_ch0_out = 1'b0;
    endtask : t_sync

    task automatic t_fault();
        {analog_comparator_out, fault_pin_one} = 2'h3;
        lat(7, 1'b1, 3);
        fault_pin_two = 1'b1;
        lat(8, 1'b1, 3);
        chk_vec(obs[9:6], 4'h7);
        {analog_comparator_out, fault_pin_one, fault_pin_two} = 3'h0;
        repeat (4) cyc();
    endtask : t_fault

    task automatic t_route();
        for (int i = 0; i < 32; i++)
        begin
            {opt_tx_mod, opt_cmp_capture, opt_cmp_rx, analog_comparator_out,
             timer_b_ch0_pin} = i[4:0];
            {serial_zero_rx_pin, timer_a_ch0_out} = {2{!i[0]}};
            serial_zero_tx = i[1];
            // Pin paths settle only after the synchroniser
            repeat (3) cyc();
            chk_vec(obs[5], i[3] ? i[1] : i[0]);
            chk_vec(obs[3], i[2] ? i[1] : !i[0]);
            chk_vec(obs[4], i[2] ? i[1] : !i[0]);
            chk_vec(obs[2], i[4] ? i[1] & !i[0] : i[1]);
        end
    endtask : t_route

    // Every source against every select; only the chosen one may fire
    task automatic t_trig();
        logic hit;
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 4; k++)
            begin
                opt_trg_sel = s[1:0];
                opt_trg_delay = 8'hff;
                kind = k[1:0];
                lane = 3'h5;
                go = 1'b1;
                if (s == k)
                begin
                    lat(1, 1'b1, s > 1 ? 257 : 1);
                    cyc();
                    chk_vec(obs[1], 1'b0);
                end
                else
                begin
                    cyc();
                    go = 1'b0;
                    hit = obs[1];
                    repeat (260)
                    begin
                        cyc();
                        hit |= obs[1];
                    end
                    chk_vec(hit, 1'b0);
                end
            end
    endtask : t_trig

    task automatic t_match();
        opt_trg_sel = 2'h2;
        kind = 2'h2;
        for (int l = 0; l < 6; l++)
        begin
            opt_trg_delay = l[7:0];
            lane = l[2:0];
            go = 1'b1;
            lat(1, 1'b1, l + 2);
            cyc();
        end
    endtask : t_match

    task automatic t_rtc();
        {opt_trg_sel, kind} = 4'h1;
        opt_rtc_pin_en = 1'b1;
        go = 1'b1;
        lat(0, 1'b1, 1);
        cyc();
        go = 1'b1;
        lat(0, 1'b0, 1);
        opt_rtc_pin_en = 1'b0;
        cyc();
        go = 1'b1;
        repeat (3) cyc();
        chk_vec(obs[0], 1'b0);
    endtask : t_rtc

    initial
    begin
        arst_n = 1'b0;
        {opt_cmp_capture, opt_cmp_rx, opt_tx_mod, opt_rtc_pin_en} = 4'h0;
        {opt_trg_sel, opt_trg_delay} = 10'h000;
        {sw_pwm_sync_bit, analog_comparator_out, timer_a_ch0_out} = 3'h0;
        {serial_zero_tx, fault_pin_one, fault_pin_two} = 3'h0;
        {timer_b_ch0_pin, serial_zero_rx_pin} = 2'h3;
        {kind, lane, go} = 6'h00;
        repeat (2) @(negedge clk_sys);
        // Receive and transmit lines idle high in reset
        chk_vec(obs, 13'h001c);
        arst_n = 1'b1;
        repeat (3) cyc();
        t_sync();
        t_fault();
        t_route();
        t_trig();
        t_match();
        t_rtc();
        complete_run();
    end

    // Whole run needs about 4000 cycles
    initial
    begin
        #(25 * 12000);
        n_mismatch++;
        complete_run();
    end
endmodule : timer_trigger_interconnect_test
